//--- src/sdc_pkg.sv
// Shared constants, types and helpers for the command decoder and controller
package sdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int SDC_BA_W = 3;
  localparam int SDC_ADDR_W = 15;
  localparam int SDC_AP_BIT = 10;
  localparam int SDC_BC_BIT = 12;
  localparam int SDC_MR_SEL_W = 2;

  // Pin encodings of {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] SDC_ENC_MRS = 4'h0;
  localparam logic [3:0] SDC_ENC_REF = 4'h1;
  localparam logic [3:0] SDC_ENC_PRE = 4'h2;
  localparam logic [3:0] SDC_ENC_ACT = 4'h3;
  localparam logic [3:0] SDC_ENC_WR = 4'h4;
  localparam logic [3:0] SDC_ENC_RD = 4'h5;
  localparam logic [3:0] SDC_ENC_ZQ = 4'h6;
  localparam logic [3:0] SDC_ENC_NOP = 4'h7;
  localparam logic [3:0] SDC_ENC_DES = 4'hf;

  // Burst-length field of mode register zero
  localparam int SDC_MR0_BL_LSB = 0;
  localparam logic [1:0] SDC_BL_FIX8 = 2'h0;
  localparam logic [1:0] SDC_BL_OTF = 2'h1;
  localparam logic [1:0] SDC_BL_FIX4 = 2'h2;
  localparam logic [SDC_ADDR_W-1:0] SDC_MR_RST = 15'h0000;

  // Timing counts in clock cycles
  localparam logic [4:0] SDC_BL8_CK = 5'h04;
  localparam logic [4:0] SDC_BC4_CK = 5'h02;
  localparam int SDC_ZQINIT_CK = 512;
  localparam int SDC_ZQOPER_CK = 256;
  localparam int SDC_ZQCS_CK = 64;
  localparam int SDC_WAIT_W = 10;

  // Controller register map and fields
  localparam logic [7:0] SDC_REG_CMD = 8'h00;
  localparam logic [7:0] SDC_REG_ADDR = 8'h04;
  localparam logic [7:0] SDC_REG_STAT = 8'h08;
  localparam int SDC_CMD_LSB = 0;
  localparam int SDC_BANK_LSB = 4;
  localparam int SDC_ST_BUSY_BIT = 0;
  localparam int SDC_ST_STATE_LSB = 1;
  localparam int SDC_ST_ERR_BIT = 3;
  localparam int SDC_ST_OPEN_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    SDC_NOP = 4'b0000,
    SDC_MRS = 4'b0001,
    SDC_REF = 4'b0010,
    SDC_SRE = 4'b0011,
    SDC_SRX = 4'b0100,
    SDC_PRE = 4'b0101,
    SDC_ACT = 4'b0110,
    SDC_WR = 4'b0111,
    SDC_RD = 4'b1000,
    SDC_PDE = 4'b1001,
    SDC_PDX = 4'b1010,
    SDC_ZQ = 4'b1011,
    SDC_DES = 4'b1100,
    SDC_ILL = 4'b1111
  } sdc_cmd_t;

  typedef enum logic [1:0] {
    SDC_ST_IDLE = 2'b00,
    SDC_ST_PDOWN = 2'b01,
    SDC_ST_SREF = 2'b10
  } sdc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  function automatic sdc_cmd_t sdc_decode(input logic [3:0] enc);
    sdc_cmd_t c;
    c = SDC_DES;
    if (enc == SDC_ENC_MRS) c = SDC_MRS;
    else if (enc == SDC_ENC_REF) c = SDC_REF;
    else if (enc == SDC_ENC_PRE) c = SDC_PRE;
    else if (enc == SDC_ENC_ACT) c = SDC_ACT;
    else if (enc == SDC_ENC_WR) c = SDC_WR;
    else if (enc == SDC_ENC_RD) c = SDC_RD;
    else if (enc == SDC_ENC_ZQ) c = SDC_ZQ;
    else if (enc == SDC_ENC_NOP) c = SDC_NOP;
    return c;
  endfunction

  function automatic logic [3:0] sdc_encode(input sdc_cmd_t c);
    logic [3:0] e;
    e = SDC_ENC_DES;
    case (c)
      SDC_MRS: e = SDC_ENC_MRS;
      SDC_REF, SDC_SRE: e = SDC_ENC_REF;
      SDC_PRE: e = SDC_ENC_PRE;
      SDC_ACT: e = SDC_ENC_ACT;
      SDC_WR: e = SDC_ENC_WR;
      SDC_RD: e = SDC_ENC_RD;
      SDC_ZQ: e = SDC_ENC_ZQ;
      SDC_NOP, SDC_PDE, SDC_PDX: e = SDC_ENC_NOP;
      default: e = SDC_ENC_DES;
    endcase
    return e;
  endfunction

endpackage

//--- src/sdc_cmd_if.sv
// Command bus between memory controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface sdc_cmd_if #(
  parameter int BA_W = 3,
  parameter int ADDR_W = 15
);
  logic reset_n;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;

  modport ctrl (
    output reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr
  );
  modport dram (
    input reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr
  );
endinterface
`default_nettype wire

//--- src/sdc_dram_end.sv
// Memory-device end: command decode, power states, banks and mode registers
//
// Overview of operation
// - Decode only from pins sampled at edge
// - Active-low reset is asynchronous, held high otherwise
// - Termination control never alters decoding
// - Bank address picks bank or mode register
// - MRS, refresh, precharge, activate pin encodings
// - Write/read encodings, A10 auto-precharge, A12 chop
// - CKE edges enter and exit power states
// - ZQ calibration encoding, A10 long/short
// - Self refresh exit ignores command decode
// - Bursts always run to completion
// - MR0 field picks fixed or on-the-fly length
// - No-op registers nothing, stops nothing
// - Deselect behaves as no-op
// - No refresh while in power-down
// - Address field widths follow configuration
// - Chip select high accepts no command
// - No-op is CS low, others high
// - Controller precharges before new row
// - Controller waits out calibration windows
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sdc_dram_end
  import sdc_pkg::*;
#(
  parameter int BA_W = SDC_BA_W,
  parameter int ADDR_W = SDC_ADDR_W
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  sdc_cmd_if.dram bus,
  input wire logic [SDC_MR_SEL_W-1:0] mr_sel_in,
  output logic cmd_valid_out,
  output sdc_cmd_t cmd_out,
  output logic [BA_W-1:0] bank_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic auto_pre_out,
  output logic all_bank_out,
  output logic chop_out,
  output logic zq_long_out,
  output logic illegal_out,
  output sdc_state_t state_out,
  output logic burst_busy_out,
  output logic [(1<<BA_W)-1:0] bank_open_out,
  output logic [ADDR_W-1:0] mr_data_out
);

  localparam int NB = 1 << BA_W;

  ////////////////////////////////////////////////////////////////////////////
  // Decode; odt is deliberately never read here
  sdc_state_t state;
  sdc_state_t next_state;
  logic cke_q;
  logic [4:0] burst_cnt;
  logic [4:0] next_burst_cnt;
  logic [NB-1:0] ap_mask;
  logic [NB-1:0] next_ap_mask;
  logic [NB-1:0] next_open;
  logic [ADDR_W-1:0] mode_reg [4];
  sdc_cmd_t acc_cmd;
  logic ill;

  wire logic [3:0] pin_enc = {bus.cs_n, bus.ras_n, bus.cas_n,
    bus.we_n};
  wire sdc_cmd_t dec = sdc_decode(pin_enc);
  wire logic nop_like = (dec == SDC_NOP) || (dec == SDC_DES);
  wire logic cke_fall = cke_q && !bus.cke;
  wire logic cke_rise = !cke_q && bus.cke;
  wire logic a10 = bus.addr[SDC_AP_BIT];
  wire logic [1:0] bl_mode = mode_reg[0][SDC_MR0_BL_LSB+:2];
  wire logic otf = (bl_mode == SDC_BL_OTF);
  wire logic chop = otf ? !bus.addr[SDC_BC_BIT]
    : (bl_mode == SDC_BL_FIX4);
  wire logic [4:0] burst_len = chop ? SDC_BC4_CK : SDC_BL8_CK;
  wire logic is_rw = (acc_cmd == SDC_RD) || (acc_cmd == SDC_WR);
  wire logic [NB-1:0] bank_bit = NB'(1) << bus.ba;
  wire logic burst_end = (burst_cnt == 5'h01);
  wire logic [4:0] burst_run = (burst_cnt != 5'h00)
    ? burst_cnt - 5'h01 : 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Power-state machine and accepted command
  always_comb
  begin
    next_state = state;
    acc_cmd = SDC_NOP;
    ill = 1'b0;
    case (state)
      SDC_ST_IDLE:
      begin
        if (cke_fall)
        begin
          if (dec == SDC_REF)
          begin
            next_state = SDC_ST_SREF;
            acc_cmd = SDC_SRE;
          end
          else if (nop_like)
          begin
            next_state = SDC_ST_PDOWN;
            acc_cmd = SDC_PDE;
          end
          else
          begin
            ill = 1'b1;
          end
        end
        else if (cke_q && !nop_like)
        begin
          // MRS to a register beyond the four is not a defined command
          if (dec == SDC_MRS && bus.ba[BA_W-1:SDC_MR_SEL_W] != '0)
          begin
            ill = 1'b1;
          end
          else
          begin
            acc_cmd = dec;
          end
        end
      end
      SDC_ST_PDOWN:
      begin
        // Refresh never runs here, whatever sits on the pins
        if (cke_rise)
        begin
          if (nop_like)
          begin
            next_state = SDC_ST_IDLE;
            acc_cmd = SDC_PDX;
          end
          else
          begin
            ill = 1'b1;
          end
        end
      end
      SDC_ST_SREF:
      begin
        if (bus.cke)
        begin
          next_state = SDC_ST_IDLE;
          acc_cmd = SDC_SRX;
        end
      end
      default:
      begin
        next_state = SDC_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bursts and banks
  always_comb
  begin
    next_burst_cnt = burst_run;
    next_ap_mask = ap_mask;
    next_open = bank_open_out;
    if (burst_end)
    begin
      next_open = next_open & ~ap_mask;
      next_ap_mask = '0;
    end
    if (is_rw)
    begin
      // A new burst queues behind the running one, never cuts it
      next_burst_cnt = burst_run + burst_len;
      if (a10)
      begin
        next_ap_mask = next_ap_mask | bank_bit;
      end
    end
    if (acc_cmd == SDC_ACT)
    begin
      next_open = next_open | bank_bit;
    end
    else if (acc_cmd == SDC_PRE)
    begin
      next_open = a10 ? '0 : (next_open & ~bank_bit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in or negedge bus.reset_n)
  begin
    if (!bus.reset_n || rst_in)
    begin
      state <= SDC_ST_IDLE;
      cke_q <= 1'b1;
      burst_cnt <= 5'h00;
      ap_mask <= '0;
      bank_open_out <= '0;
      for (int i = 0; i < 4; i++)
      begin
        mode_reg[i] <= SDC_MR_RST;
      end
    end
    else
    begin
      state <= next_state;
      cke_q <= bus.cke;
      burst_cnt <= next_burst_cnt;
      ap_mask <= next_ap_mask;
      bank_open_out <= next_open;
      if (acc_cmd == SDC_MRS)
      begin
        mode_reg[bus.ba[SDC_MR_SEL_W-1:0]] <= bus.addr;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge bus.reset_n)
  begin
    if (!bus.reset_n || rst_in)
    begin
      cmd_valid_out <= 1'b0;
      cmd_out <= SDC_NOP;
      bank_out <= '0;
      addr_out <= '0;
      auto_pre_out <= 1'b0;
      all_bank_out <= 1'b0;
      chop_out <= 1'b0;
      zq_long_out <= 1'b0;
      illegal_out <= 1'b0;
    end
    else
    begin
      cmd_valid_out <= (acc_cmd != SDC_NOP);
      cmd_out <= acc_cmd;
      bank_out <= bus.ba;
      addr_out <= bus.addr;
      auto_pre_out <= is_rw && a10;
      all_bank_out <= (acc_cmd == SDC_PRE) && a10;
      chop_out <= is_rw && chop;
      zq_long_out <= (acc_cmd == SDC_ZQ) && a10;
      illegal_out <= ill;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign state_out = state;
  assign burst_busy_out = (burst_cnt != 5'h00);
  assign mr_data_out = mode_reg[mr_sel_in];

endmodule
`default_nettype wire

//--- src/sdc_ctrl_end.sv
// Controller end: register port orders, drives the command pins
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_end
  import sdc_pkg::*;
#(
  parameter int BA_W = SDC_BA_W,
  parameter int ADDR_W = SDC_ADDR_W,
  parameter int ZQINIT_CK = SDC_ZQINIT_CK,
  parameter int ZQOPER_CK = SDC_ZQOPER_CK,
  parameter int ZQCS_CK = SDC_ZQCS_CK
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  sdc_cmd_if.ctrl bus
);

  localparam int NB = 1 << BA_W;

  ////////////////////////////////////////////////////////////////////////////
  sdc_state_t state;
  logic [SDC_WAIT_W-1:0] wait_cnt;
  logic [NB-1:0] open_mask;
  logic [ADDR_W-1:0] addr_reg;
  logic zq_done;
  logic err;
  logic reset_n;
  logic cke;
  logic [3:0] pins;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  sdc_state_t next_state;
  logic legal;

  wire logic cmd_wr = reg_wr_in && (reg_addr_in == SDC_REG_CMD);
  wire logic addr_wr = reg_wr_in && (reg_addr_in == SDC_REG_ADDR);
  wire logic stat_rd = reg_rd_in && (reg_addr_in == SDC_REG_STAT);
  wire sdc_cmd_t req = sdc_cmd_t'(reg_wdata_in[SDC_CMD_LSB+:4]);
  wire logic [BA_W-1:0] req_ba = reg_wdata_in[SDC_BANK_LSB+:BA_W];
  wire logic [NB-1:0] req_bit = NB'(1) << req_ba;
  wire logic bank_open = |(open_mask & req_bit);
  wire logic busy = (wait_cnt != '0);
  wire logic a10 = addr_reg[SDC_AP_BIT];
  wire logic issue = cmd_wr && !busy && legal;
  wire logic [31:0] stat_word = {16'h0000, NB'(open_mask),
    4'h0, err, state, busy};

  ////////////////////////////////////////////////////////////////////////////
  // Legality and next power state of the request
  always_comb
  begin
    legal = 1'b0;
    next_state = state;
    case (state)
      SDC_ST_IDLE:
      begin
        case (req)
          SDC_ACT: legal = !bank_open;
          SDC_RD, SDC_WR: legal = bank_open;
          SDC_MRS, SDC_REF, SDC_PRE, SDC_ZQ, SDC_NOP: legal = 1'b1;
          SDC_PDE:
          begin
            legal = 1'b1;
            next_state = SDC_ST_PDOWN;
          end
          SDC_SRE:
          begin
            legal = (open_mask == '0);
            next_state = SDC_ST_SREF;
          end
          default: legal = 1'b0;
        endcase
      end
      SDC_ST_PDOWN:
      begin
        // Only exit is allowed; a refresh order is refused and flagged until the device is up
        legal = (req == SDC_PDX);
        next_state = SDC_ST_IDLE;
      end
      SDC_ST_SREF:
      begin
        legal = (req == SDC_SRX);
        next_state = SDC_ST_IDLE;
      end
      default: legal = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold-off after each command; burst and calibration windows
  function automatic logic [SDC_WAIT_W-1:0] hold(input sdc_cmd_t c,
    input logic lng, input logic first);
    logic [SDC_WAIT_W-1:0] h;
    h = SDC_WAIT_W'(1);
    if (c == SDC_RD || c == SDC_WR) h = SDC_WAIT_W'(SDC_BL8_CK);
    else if (c == SDC_ZQ && lng && first) h = SDC_WAIT_W'(ZQINIT_CK);
    else if (c == SDC_ZQ && lng) h = SDC_WAIT_W'(ZQOPER_CK);
    else if (c == SDC_ZQ) h = SDC_WAIT_W'(ZQCS_CK);
    return h;
  endfunction

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      reset_n <= 1'b0;
      cke <= 1'b1;
      pins <= SDC_ENC_DES;
      ba <= '0;
      addr <= '0;
      state <= SDC_ST_IDLE;
      wait_cnt <= '0;
      open_mask <= '0;
      addr_reg <= '0;
      zq_done <= 1'b0;
      err <= 1'b0;
      reg_rdata_out <= 32'h0000_0000;
    end
    else
    begin
      reset_n <= 1'b1;
      pins <= SDC_ENC_DES;
      reg_rdata_out <= stat_rd ? stat_word : 32'h0000_0000;
      wait_cnt <= busy ? wait_cnt - SDC_WAIT_W'(1) : wait_cnt;
      if (addr_wr)
      begin
        addr_reg <= reg_wdata_in[ADDR_W-1:0];
      end
      // A refused order sets the error flag; set wins over read-clear
      if (cmd_wr && !issue)
      begin
        err <= 1'b1;
      end
      else if (stat_rd)
      begin
        err <= 1'b0;
      end
      if (issue)
      begin
        pins <= sdc_encode(req);
        ba <= req_ba;
        addr <= addr_reg;
        state <= next_state;
        wait_cnt <= hold(req, a10, !zq_done);
        if (req == SDC_PDE || req == SDC_SRE) cke <= 1'b0;
        if (req == SDC_PDX || req == SDC_SRX) cke <= 1'b1;
        if (req == SDC_ZQ && a10) zq_done <= 1'b1;
        if (req == SDC_ACT) open_mask <= open_mask | req_bit;
        if (req == SDC_PRE) open_mask <= a10 ? '0 : open_mask & ~req_bit;
        if ((req == SDC_RD || req == SDC_WR) && a10)
        begin
          open_mask <= open_mask & ~req_bit;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign bus.reset_n = reset_n;
  assign bus.cke = cke;
  assign bus.cs_n = pins[3];
  assign bus.ras_n = pins[2];
  assign bus.cas_n = pins[1];
  assign bus.we_n = pins[0];
  // Termination rides with writes; the decoder must not care
  assign bus.odt = (pins == SDC_ENC_WR);
  assign bus.ba = ba;
  assign bus.addr = addr;

endmodule
`default_nettype wire

//--- verif/sdc_cmd_sva.sv
// Concurrent checks on the command bus and the decoder's answers
`timescale 1ns/1ps
`default_nettype none
module sdc_cmd_sva
  import sdc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [SDC_BA_W-1:0] ba,
  input wire logic [SDC_ADDR_W-1:0] addr,
  input wire logic cmd_valid_out,
  input wire sdc_cmd_t cmd_out,
  input wire logic auto_pre_out,
  input wire logic zq_long_out,
  input wire logic illegal_out,
  input wire sdc_state_t state_out,
  input wire logic [7:0] bank_open_out
);
  default clocking sva_cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  // Clock enable high at this edge and the one before
  sequence s_cmd(logic [3:0] enc);
    reset_n && $past(cke) && cke && {cs_n, ras_n, cas_n, we_n} == enc;
  endsequence
  // Falling clock enable from the idle state
  sequence s_cke_fall;
    reset_n && state_out == SDC_ST_IDLE && $past(cke) && !cke;
  endsequence
  ////////////////////////////////////////
  AST_MRS_DEC: assert property (
    s_cmd(SDC_ENC_MRS) ##0 !ba[2] |=> cmd_valid_out && cmd_out == SDC_MRS)
    else $error("mode register set not decoded");
  AST_MRS_ILL: assert property (
    s_cmd(SDC_ENC_MRS) ##0 ba[2] |=> illegal_out && !cmd_valid_out)
    else $error("undefined mode register accepted");
  AST_ACT_OPEN: assert property (
    s_cmd(SDC_ENC_ACT) |=> cmd_out == SDC_ACT && bank_open_out[$past(ba)])
    else $error("activate did not open the addressed bank");
  AST_PRE_DEC: assert property (
    s_cmd(SDC_ENC_PRE) |=> cmd_valid_out && cmd_out == SDC_PRE)
    else $error("precharge not decoded");
  AST_REF_DEC: assert property (
    s_cmd(SDC_ENC_REF) |=> cmd_valid_out && cmd_out == SDC_REF)
    else $error("refresh not decoded");
  AST_RD_AP: assert property (
    s_cmd(SDC_ENC_RD) |=> cmd_out == SDC_RD && auto_pre_out == $past(addr[10]))
    else $error("read or its auto precharge wrong");
  AST_WR_AP: assert property (
    s_cmd(SDC_ENC_WR) |=> cmd_out == SDC_WR && auto_pre_out == $past(addr[10]))
    else $error("write or its auto precharge wrong");
  AST_ZQ_LONG: assert property (
    s_cmd(SDC_ENC_ZQ) |=> cmd_out == SDC_ZQ && zq_long_out == $past(addr[10]))
    else $error("calibration kind wrong");
  AST_NOP_QUIET: assert property (
    s_cmd(SDC_ENC_NOP) |=> !cmd_valid_out && !illegal_out)
    else $error("no-op registered something");
  AST_DES_QUIET: assert property (
    reset_n && $past(cke) && cke && cs_n |=> !cmd_valid_out && !illegal_out)
    else $error("deselect registered something");
  AST_SRE_ENTRY: assert property (
    s_cke_fall ##0 {cs_n, ras_n, cas_n, we_n} == SDC_ENC_REF
    |=> state_out == SDC_ST_SREF && cmd_out == SDC_SRE)
    else $error("self refresh not entered");
  AST_PDE_ENTRY: assert property (
    s_cke_fall ##0 (cs_n || {cs_n, ras_n, cas_n, we_n} == SDC_ENC_NOP)
    |=> state_out == SDC_ST_PDOWN && cmd_out == SDC_PDE)
    else $error("power-down not entered");
  AST_PD_HOLD: assert property (
    reset_n && state_out == SDC_ST_PDOWN && !cke
    |=> state_out == SDC_ST_PDOWN && !cmd_valid_out)
    else $error("activity during power-down");
  AST_SRX_ASYNC: assert property (
    reset_n && state_out == SDC_ST_SREF && cke
    |=> state_out == SDC_ST_IDLE && cmd_out == SDC_SRX)
    else $error("self refresh exit missed");
  AST_RESET_HELD: assert property (
    !$past(rst_in) |-> reset_n)
    else $error("device reset low in normal operation");
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Testbench joining controller and device ends over the command bus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sdc_pkg::*;
  typedef struct packed {sdc_cmd_t c; logic [2:0] b; logic [14:0] a;
    logic f; logic ch;} sdc_exp_t;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [1:0] mr_sel_in = 2'h0;
  logic [31:0] reg_rdata_out;
  logic cmd_valid_out, auto_pre_out, all_bank_out, chop_out;
  logic zq_long_out, illegal_out, burst_busy_out, rd_seen = 1'b0;
  sdc_cmd_t cmd_out;
  sdc_state_t state_out;
  logic [2:0] bank_out;
  logic [7:0] bank_open_out;
  logic [14:0] mr_data_out;
  logic [14:0] addr_out;
  logic [1:0] mr0_mode = SDC_BL_FIX8;
  sdc_exp_t cmd_q[$];
  logic [31:0] rd_q[$];
  int n_fail = 0;
  int checked = 0;
  always #2 core_clk_in = ~core_clk_in;
  ////////////////////////////////////////
  sdc_cmd_if #(.BA_W(3), .ADDR_W(15)) cmd_bus ();
  // Short calibration windows keep the run brief
  sdc_ctrl_end #(.ZQINIT_CK(8), .ZQOPER_CK(8), .ZQCS_CK(8)) sdc_ctrl_end_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .bus(cmd_bus));
  sdc_dram_end sdc_dram_end_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .bus(cmd_bus),
    .mr_sel_in(mr_sel_in), .cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out),
    .bank_out(bank_out), .addr_out(addr_out), .auto_pre_out(auto_pre_out),
    .all_bank_out(all_bank_out), .chop_out(chop_out),
    .zq_long_out(zq_long_out), .illegal_out(illegal_out),
    .state_out(state_out), .burst_busy_out(burst_busy_out),
    .bank_open_out(bank_open_out), .mr_data_out(mr_data_out));
  sdc_cmd_sva sdc_cmd_sva_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reset_n(cmd_bus.reset_n),
    .cke(cmd_bus.cke), .cs_n(cmd_bus.cs_n), .ras_n(cmd_bus.ras_n),
    .cas_n(cmd_bus.cas_n), .we_n(cmd_bus.we_n), .ba(cmd_bus.ba),
    .addr(cmd_bus.addr), .cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out),
    .auto_pre_out(auto_pre_out), .zq_long_out(zq_long_out),
    .illegal_out(illegal_out), .state_out(state_out),
    .bank_open_out(bank_open_out));
  ////////////////////////////////////////
  task automatic fail(input string m);
    n_fail++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic cmp_cmd(input sdc_exp_t e);
    logic fl, ch;
    fl = e.f;
    ch = e.ch;
    if (e.c == SDC_PRE) fl = all_bank_out;
    if (e.c == SDC_ZQ) fl = zq_long_out;
    if (e.c inside {SDC_RD, SDC_WR})
    begin
      fl = auto_pre_out;
      ch = chop_out;
    end
    checked++;
    if (cmd_out !== e.c || fl !== e.f || ch !== e.ch) fail("command flags");
    if (e.c inside {SDC_MRS, SDC_ACT, SDC_RD, SDC_WR} &&
        (bank_out !== e.b || addr_out !== e.a)) fail("bank or address");
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) fail("word");
  endtask
  function automatic logic [31:0] stat(sdc_state_t s, logic er,
    logic [7:0] ob);
    return {16'h0000, ob, 4'h0, er, s, 1'b0};
  endfunction
  // Outputs are settled mid-cycle, so results are taken at the falling edge
  always @(posedge core_clk_in) rd_seen <= reg_rd_in;
  always @(negedge core_clk_in)
  begin
    if (!rst_in && cmd_out !== SDC_NOP)
    begin
      if (cmd_q.size() == 0) fail("unexpected command");
      else cmp_cmd(cmd_q.pop_front());
    end
    if (rd_seen) cmp_word(reg_rdata_out, rd_q.pop_front());
  end
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
  endtask
  task automatic iss(input sdc_cmd_t c, input logic [2:0] b,
                     input logic [14:0] a, input int w);
    sdc_exp_t e;
    e.c = c;
    e.b = b;
    e.a = a;
    e.f = (c inside {SDC_PRE, SDC_ZQ, SDC_RD, SDC_WR}) ? a[10] : 1'b0;
    e.ch = (mr0_mode == SDC_BL_OTF) ? !a[12] : (mr0_mode == SDC_BL_FIX4);
    if (!(c inside {SDC_RD, SDC_WR})) e.ch = 1'b0;
    if (!(c inside {SDC_NOP, SDC_DES})) cmd_q.push_back(e);
    wr(SDC_REG_ADDR, {17'h0, a});
    wr(SDC_REG_CMD, {25'h0, b, c});
    repeat (w) @(posedge core_clk_in);
  endtask
  task end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge core_clk_in);
    fail("watchdog");
    end_of_test();
  end
  initial
  begin
    logic [14:0] op;
    logic [2:0] bk;
    void'($urandom(96018));
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(SDC_REG_STAT, stat(SDC_ST_IDLE, 1'b0, 8'h00));
    rd(8'h0c, 32'h0);
    $display("test reset done");
    for (int i = 3; i >= 0; i--)
    begin
      op = 15'($urandom());
      if (i == 0) op[1:0] = SDC_BL_FIX8;
      iss(SDC_MRS, 3'(i), op, 2);
      mr_sel_in <= 2'(i);
      @(negedge core_clk_in);
      cmp_word({17'h0, mr_data_out}, {17'h0, op});
    end
    // A fifth mode register does not exist: flagged, nothing written
    wr(SDC_REG_ADDR, {17'h0, ~op});
    wr(SDC_REG_CMD, {25'h0, 3'h4, SDC_MRS});
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    cmp_word({17'h0, mr_data_out}, {17'h0, op});
    $display("test mode registers done");
    bk = 3'($urandom());
    iss(SDC_ACT, bk, 15'($urandom()), 2);
    rd(SDC_REG_STAT, stat(SDC_ST_IDLE, 1'b0, 8'h01 << bk));
    // Fixed length ignores the chop bit
    iss(SDC_RD, bk, 15'h1000, 6);
    iss(SDC_WR, bk, 15'h0000, 6);
    mr0_mode = SDC_BL_OTF;
    iss(SDC_MRS, 3'h0, {13'h0, SDC_BL_OTF}, 2);
    iss(SDC_WR, bk, 15'h1000, 6);
    iss(SDC_RD, bk, 15'h0400, 6);
    iss(SDC_ACT, bk, 15'h0000, 2);
    // Fixed chop ignores the A12 bit as well
    mr0_mode = SDC_BL_FIX4;
    iss(SDC_MRS, 3'h0, {13'h0, SDC_BL_FIX4}, 2);
    iss(SDC_RD, bk, 15'h1000, 6);
    mr0_mode = SDC_BL_OTF;
    iss(SDC_MRS, 3'h0, {13'h0, SDC_BL_OTF}, 2);
    // A read ordered mid-burst is turned away, the write runs on
    iss(SDC_WR, bk, 15'h1000, 0);
    wr(SDC_REG_CMD, {25'h0, bk, SDC_RD});
    @(negedge core_clk_in);
    cmp_word({31'h0, burst_busy_out}, 32'h1);
    repeat (2) @(negedge core_clk_in);
    cmp_word({31'h0, burst_busy_out}, 32'h1);
    @(negedge core_clk_in);
    cmp_word({31'h0, burst_busy_out}, 32'h0);
    repeat (4) @(posedge core_clk_in);
    rd(SDC_REG_STAT, stat(SDC_ST_IDLE, 1'b1, 8'h01 << bk));
    iss(SDC_PRE, 3'h0, 15'h0400, 2);
    $display("test bursts done");
    iss(SDC_REF, 3'h0, 15'h0, 2);
    iss(SDC_NOP, 3'h0, 15'h7fff, 2);
    iss(SDC_DES, 3'h7, 15'h7fff, 2);
    // A deselect order is refused; the pins idle at deselect anyway
    rd(SDC_REG_STAT, stat(SDC_ST_IDLE, 1'b1, 8'h00));
    iss(SDC_ZQ, 3'h5, 15'h0400, 12);
    for (int i = 0; i < 6; i++)
      iss(SDC_ZQ, 3'($urandom()), 15'($urandom()), 12);
    $display("test refresh and calibration done");
    iss(SDC_PDE, 3'h0, 15'h0, 2);
    rd(SDC_REG_STAT, stat(SDC_ST_PDOWN, 1'b0, 8'h00));
    wr(SDC_REG_CMD, {25'h0, 3'h0, SDC_REF});
    rd(SDC_REG_STAT, stat(SDC_ST_PDOWN, 1'b1, 8'h00));
    iss(SDC_PDX, 3'h0, 15'h0, 2);
    iss(SDC_SRE, 3'h0, 15'h0, 2);
    rd(SDC_REG_STAT, stat(SDC_ST_SREF, 1'b0, 8'h00));
    iss(SDC_SRX, 3'h0, 15'h0, 2);
    rd(SDC_REG_STAT, stat(SDC_ST_IDLE, 1'b0, 8'h00));
    repeat (4) @(posedge core_clk_in);
    if (cmd_q.size() != 0) fail("command missing");
    $display("test power states done");
    end_of_test();
  end
endmodule
`default_nettype wire
